// >>> design/efuse_seq.sv
// Start-up sequencing and protection control for an electronic fuse switch.
// Assumes comparator results arrive asynchronously and thresholds feed analog DACs.
`include "efuse_seq_defs.svh"
`timescale 1ns/1ps
`default_nettype none

module efuse_seq #(
	parameter int INS_STEP_CYC     = `INS_STEP_US * `CLK_MHZ,
	parameter int ARM_CYC          = (`DISCHARGE_ARM_NS * `CLK_MHZ + 999) / 1000,
	parameter int SU_TIMEOUT_CYC   = `STARTUP_TIMEOUT_US * `CLK_MHZ,
	parameter int OC_STEP_CYC      = (`OC_STEP_NS * `CLK_MHZ + 999) / 1000,
	parameter int RETRY_STEP_CYC   = `RETRY_STEP_MS * 1000 * `CLK_MHZ
) (
	input  wire logic        CLOCK,
	input  wire logic        RESET_N,
	input  wire logic        BIAS_ABOVE_UVP,
	input  wire logic        ENABLE_ABOVE_ON,
	input  wire logic        ENABLE_ABOVE_SHUTDOWN,
	input  wire logic        SWITCH_ENABLE,
	input  wire logic        INPUT_BELOW_UV,
	input  wire logic        INPUT_ABOVE_OV,
	input  wire logic        CURRENT_ABOVE_BREAKER,
	input  wire logic        CURRENT_ABOVE_PROG_TRIP,
	input  wire logic        CURRENT_ABOVE_FIXED_TRIP,
	input  wire logic        THERMAL_SHUTDOWN,
	input  wire logic        SWITCH_FULLY_ON,
	input  wire logic        NVM_VALID,
	input  wire logic [7:0]  NVM_INSERTION_DELAY,
	input  wire logic [7:0]  NVM_UV_LIMIT,
	input  wire logic [7:0]  NVM_OV_LIMIT,
	input  wire logic [7:0]  NVM_BLANKING,
	input  wire logic [1:0]  NVM_SLEW_SCALE,
	input  wire logic        NVM_AUTO_RETRY,
	input  wire logic        WRITE_UV_LIMIT,
	input  wire logic        WRITE_OV_LIMIT,
	input  wire logic        WRITE_SLEW_SCALE,
	input  wire logic        WRITE_BLANKING,
	input  wire logic [7:0]  WRITE_DATA,
	output logic             SWITCH_ON,
	output logic             SLEW_CONTROLLED,
	output logic [1:0]       SLEW_SCALE,
	output logic [7:0]       INPUT_UNDERVOLTAGE_LIMIT,
	output logic [7:0]       INPUT_OVERVOLTAGE_LIMIT,
	output logic             OUTPUT_DISCHARGE,
	output logic             FAULT_OUTPUT_N,
	output logic [7:0]       VENDOR_STATUS,
	output logic [2:0]       SEQ_STATE
);
	import efuse_seq_pkg::*;

	localparam int NSYNC = 11;

	// Two-stage synchronisers; the first stage feeds only the second
	logic [NSYNC-1:0] async_in;
	logic [NSYNC-1:0] meta_r;
	logic [NSYNC-1:0] sync_r;
	assign async_in = {BIAS_ABOVE_UVP, ENABLE_ABOVE_ON, ENABLE_ABOVE_SHUTDOWN, SWITCH_ENABLE,
		INPUT_BELOW_UV, INPUT_ABOVE_OV, CURRENT_ABOVE_BREAKER, CURRENT_ABOVE_PROG_TRIP,
		CURRENT_ABOVE_FIXED_TRIP, THERMAL_SHUTDOWN, SWITCH_FULLY_ON};
	genvar gi;
	generate
		for (gi = 0; gi < NSYNC; gi++) begin : g_sync
			always_ff @(posedge CLOCK or negedge RESET_N) begin
				if (!RESET_N) begin
					meta_r[gi] <= 1'b0;
					sync_r[gi] <= 1'b0;
				end else begin
					meta_r[gi] <= async_in[gi];
					sync_r[gi] <= meta_r[gi];
				end
			end
		end
	endgenerate

	logic bias_ok, en_on, en_alive, switch_enable, in_uv, in_ov, oc, trip_prog, trip_fixed, hot, fully_on;
	assign {bias_ok, en_on, en_alive, switch_enable, in_uv, in_ov, oc, trip_prog, trip_fixed, hot, fully_on} = sync_r;

	// Configuration: loaded from memory image; limits, slew and blanking overwritten by host writes
	logic [7:0] insertion_delay_setting_r, insertion_delay_setting_nxt, uv_r, uv_nxt, ov_r, ov_nxt, blank_r, blank_nxt;
	logic [1:0] slew_r, slew_nxt;
	logic       retry_r, retry_nxt, loaded_r, loaded_nxt;
	logic       shutdown;
	assign shutdown = !en_alive;

	always_comb begin
		insertion_delay_setting_nxt = insertion_delay_setting_r;
		uv_nxt      = uv_r;
		ov_nxt      = ov_r;
		blank_nxt   = blank_r;
		slew_nxt    = slew_r;
		retry_nxt   = retry_r;
		loaded_nxt  = loaded_r;
		if (shutdown) begin
			// Full shutdown drops every written value back to defaults
			insertion_delay_setting_nxt = `INSERTION_DELAY_SETTING_DEFAULT;
			uv_nxt      = `UV_LIMIT_DEFAULT;
			ov_nxt      = `OV_LIMIT_DEFAULT;
			blank_nxt   = `OVERCURRENT_BLANKING_TIMER_DEFAULT;
			slew_nxt    = `SLEW_SCALE_DEFAULT;
			retry_nxt   = 1'b0;
			loaded_nxt  = 1'b0;
		end else if (!loaded_r && NVM_VALID) begin
			// One-shot load so the part can start without a host
			insertion_delay_setting_nxt = NVM_INSERTION_DELAY;
			uv_nxt      = NVM_UV_LIMIT;
			ov_nxt      = NVM_OV_LIMIT;
			blank_nxt   = NVM_BLANKING;
			slew_nxt    = NVM_SLEW_SCALE;
			retry_nxt   = NVM_AUTO_RETRY;
			loaded_nxt  = 1'b1;
		end else begin
			if (WRITE_UV_LIMIT)
				uv_nxt = WRITE_DATA;
			if (WRITE_OV_LIMIT)
				ov_nxt = WRITE_DATA;
			if (WRITE_SLEW_SCALE)
				slew_nxt = WRITE_DATA[1:0];
			if (WRITE_BLANKING)
				blank_nxt = WRITE_DATA;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			insertion_delay_setting_r <= `INSERTION_DELAY_SETTING_DEFAULT;
			uv_r      <= `UV_LIMIT_DEFAULT;
			ov_r      <= `OV_LIMIT_DEFAULT;
			blank_r   <= `OVERCURRENT_BLANKING_TIMER_DEFAULT;
			slew_r    <= `SLEW_SCALE_DEFAULT;
			retry_r   <= 1'b0;
			loaded_r  <= 1'b0;
		end else begin
			insertion_delay_setting_r <= insertion_delay_setting_nxt;
			uv_r      <= uv_nxt;
			ov_r      <= ov_nxt;
			blank_r   <= blank_nxt;
			slew_r    <= slew_nxt;
			retry_r   <= retry_nxt;
			loaded_r  <= loaded_nxt;
		end
	end

	// Sequencer: prescaled tick counter plus unit counter shared by delays
	seq_state_t state_r, state_nxt;
	logic [31:0] tick_r, tick_nxt;
	logic [15:0] units_r, units_nxt;
	logic [31:0] su_r, su_nxt;
	logic [31:0] arm_r, arm_nxt;
	logic        dis_r, dis_nxt, flt_n_r, flt_n_nxt, su_fault_r, su_fault_nxt, ovp_r, ovp_nxt;
	logic        enables_ok, hard_fault, tick;
	logic [15:0] dly_units;
	logic [31:0] oc_pre_r, oc_pre_nxt;
	logic [7:0]  status_v;

	assign enables_ok = en_on && switch_enable;
	// Programmable trip works always; the fixed trip only once steady
	assign hard_fault = hot || trip_prog || (trip_fixed && state_r == ST_ON);
	assign tick       = (tick_r == 32'd0);
	assign dly_units  = {8'h00, insertion_delay_setting_r} + 16'd1;

	always_comb begin
		state_nxt    = state_r;
		tick_nxt     = tick ? 32'(INS_STEP_CYC - 1) : tick_r - 32'd1;
		units_nxt    = units_r;
		su_nxt       = su_r;
		arm_nxt      = arm_r;
		dis_nxt      = dis_r;
		flt_n_nxt    = flt_n_r;
		su_fault_nxt = su_fault_r;
		ovp_nxt      = in_ov;
		// Breaker prescaler reloads outside an overload so each event starts on a full step
		oc_pre_nxt   = 32'(OC_STEP_CYC - 1);
		// Standby band timer for the output discharge
		if (!en_on && en_alive) begin
			if (arm_r >= 32'(ARM_CYC - 1))
				dis_nxt = 1'b1;
			else
				arm_nxt = arm_r + 32'd1;
		end else begin
			arm_nxt = 32'd0;
			dis_nxt = 1'b0;
		end
		unique case (state_r)
			ST_LOCKOUT: begin
				units_nxt = 16'd0;
				tick_nxt  = 32'(INS_STEP_CYC - 1);
				if (bias_ok && !in_uv)
					state_nxt = ST_INSDLY;
			end
			ST_INSDLY: begin
				// Enable pin deliberately ignored here
				if (!bias_ok || in_uv)
					state_nxt = ST_LOCKOUT;
				else if (tick) begin
					if (units_r + 16'd1 >= dly_units)
						state_nxt = ST_WAIT_EN;
					else
						units_nxt = units_r + 16'd1;
				end
			end
			ST_WAIT_EN: begin
				su_nxt = 32'd0;
				if (!bias_ok || in_uv)
					state_nxt = ST_LOCKOUT;
				else if (enables_ok && !in_ov && !hard_fault)
					state_nxt = ST_STARTUP;
			end
			ST_STARTUP: begin
				su_nxt = su_r + 32'd1;
				if (!enables_ok || in_ov || hard_fault || !bias_ok || in_uv)
					state_nxt = ST_WAIT_EN;
				else if (fully_on)
					state_nxt = ST_ON;
				else if (su_r >= 32'(SU_TIMEOUT_CYC - 1)) begin
					su_fault_nxt = 1'b1;
					flt_n_nxt    = 1'b0;
					units_nxt    = 16'd0;
					state_nxt    = ST_FAULT;
				end
			end
			ST_ON: begin
				// Breaker: blanking restarts each time the overload clears
				// Own prescaler so the blanking step does not depend on the insertion delay step
				if (!oc)
					units_nxt = 16'd0;
				else if (oc_pre_r == 32'd0)
					units_nxt = units_r + 16'd1;
				else
					oc_pre_nxt = oc_pre_r - 32'd1;
				if (!enables_ok || in_ov || !bias_ok || in_uv)
					state_nxt = ST_WAIT_EN;
				else if (hard_fault || (oc && units_r >= {8'h00, blank_r})) begin
					flt_n_nxt = 1'b0;
					units_nxt = 16'd0;
					state_nxt = ST_FAULT;
				end
			end
			ST_FAULT: begin
				// Latched off unless retry enabled; one retry step per prescale
				// Limitation: the retry interval resolves only to whole insertion delay steps
				if (retry_r && tick) begin
					units_nxt = units_r + 16'd1;
					if (units_r >= 16'(RETRY_STEP_CYC / INS_STEP_CYC)) begin
						flt_n_nxt = 1'b1;
						state_nxt = ST_WAIT_EN;
					end
				end
			end
			default: state_nxt = ST_LOCKOUT;
		endcase
		if (shutdown) begin
			state_nxt    = ST_LOCKOUT;
			flt_n_nxt    = 1'b1;
			su_fault_nxt = 1'b0;
			dis_nxt      = 1'b0;
			arm_nxt      = 32'd0;
		end
	end

	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			state_r    <= ST_LOCKOUT;
			tick_r     <= 32'd0;
			units_r    <= 16'd0;
			su_r       <= 32'd0;
			arm_r      <= 32'd0;
			dis_r      <= 1'b0;
			flt_n_r    <= 1'b1;
			su_fault_r <= 1'b0;
			ovp_r      <= 1'b0;
			oc_pre_r   <= 32'd0;
		end else begin
			state_r    <= state_nxt;
			tick_r     <= tick_nxt;
			units_r    <= units_nxt;
			su_r       <= su_nxt;
			arm_r      <= arm_nxt;
			dis_r      <= dis_nxt;
			flt_n_r    <= flt_n_nxt;
			su_fault_r <= su_fault_nxt;
			ovp_r      <= ovp_nxt;
			oc_pre_r   <= oc_pre_nxt;
		end
	end

	// Switch gate is combinational so overvoltage and faults cut it at once
	assign SWITCH_ON = (state_r == ST_STARTUP || state_r == ST_ON) && enables_ok && !in_ov
		&& !hard_fault && !shutdown;
	assign SLEW_CONTROLLED          = (state_r == ST_STARTUP);
	assign SLEW_SCALE               = slew_r;
	assign INPUT_UNDERVOLTAGE_LIMIT = uv_r;
	assign INPUT_OVERVOLTAGE_LIMIT  = ov_r;
	assign OUTPUT_DISCHARGE         = dis_r;
	assign FAULT_OUTPUT_N           = flt_n_r;
	assign VENDOR_STATUS            = status_v;
	assign SEQ_STATE                = state_r;

	// Status byte: sticky start-up timeout and live overvoltage; unused bits read as zero
	always_comb begin
		status_v                      = 8'h00;
		status_v[`STATUS_STARTUP_BIT] = su_fault_r;
		status_v[`STATUS_OV_BIT]      = ovp_r;
	end
endmodule

`default_nettype wire

// >>> design/efuse_seq_defs.svh
// Constants for the electronic fuse start-up and protection sequencer.
// Assumes a 125 MHz core clock; analog comparators live outside this block.
//
// Notes on behaviour
// - Switch stays off until bias and input clear undervoltage, then insertion delay runs.
// - Switch held off for the whole insertion delay whatever the enable pin says.
// - Insertion delay length comes from a programmable setting loaded from memory.
// - After the delay, conduct only when enable pin and switch enable are both high.
// - Either enable input low turns the switch off.
// - Enable pin decodes as on, standby with state kept, or shutdown.
// - Standby longer than discharge arm time starts output discharge.
// - Enable below shutdown threshold resets faults, flags and written configuration.
// - Lockout uses fixed bias threshold and a programmable input threshold.
// - Input undervoltage limit writable at run time.
// - Input above overvoltage limit turns switch off promptly.
// - Overvoltage limit defaults internally, replaceable from memory or by writes.
// - After overvoltage clears, switch restarts through the slew-controlled path.
// - Turn-on slew scaling chosen from a configuration field.
// - Steady-state breaker with adjustable threshold and programmable blanking timer.
// - Fast trip on programmable threshold always, fixed threshold in steady state.
// - Thermal shutdown turns the switch off.
// - Thresholds and timers load at power-up without host help.
// - Start-up timeout sets status bit 6, drives fault low, latches or retries.
// - Overcurrent ending before blanking expires restores the timer.
// - Overcurrent lasting to blanking expiry trips; then latch or retry.
`ifndef EFUSE_SEQ_DEFS_SVH
`define EFUSE_SEQ_DEFS_SVH

`define CLK_MHZ              125
`define INSERTION_DELAY_SETTING_DEFAULT      8'h07
`define INS_STEP_US          80000
`define DISCHARGE_ARM_NS     4380000
`define STARTUP_TIMEOUT_US   232000
`define OVERCURRENT_BLANKING_TIMER_DEFAULT     8'h14
`define OC_STEP_NS           107000
`define RETRY_STEP_MS        55
`define SLEW_SCALE_DEFAULT   2'h2
`define STATUS_STARTUP_BIT   6
`define STATUS_OV_BIT        0
`define UV_LIMIT_DEFAULT     8'h20
`define OV_LIMIT_DEFAULT     8'hc0

`endif

// >>> design/efuse_seq_pkg.sv
// Types shared by the sequencer.
// Assumes no other package state.
package efuse_seq_pkg;
	typedef enum logic [2:0] {
		ST_LOCKOUT  = 3'b000,
		ST_INSDLY   = 3'b001,
		ST_WAIT_EN  = 3'b010,
		ST_STARTUP  = 3'b011,
		ST_ON       = 3'b100,
		ST_FAULT    = 3'b101
	} seq_state_t;
endpackage

// >>> sim/efuse_seq_props.sv
// Port-level checker for the fuse sequencer.
// Assumes it is bound to efuse_seq with the bench's shortened counts.
`timescale 1ns/1ps
`default_nettype none
module efuse_seq_props
	import efuse_seq_pkg::*;
#(
	parameter int ARM_CYC        = 20,
	parameter int SU_TIMEOUT_CYC = 50
) (
	input wire logic       CLOCK,
	input wire logic       RESET_N,
	input wire logic       ENABLE_ABOVE_ON,
	input wire logic       ENABLE_ABOVE_SHUTDOWN,
	input wire logic       SWITCH_ENABLE,
	input wire logic       INPUT_ABOVE_OV,
	input wire logic       THERMAL_SHUTDOWN,
	input wire logic       NVM_VALID,
	input wire logic       WRITE_UV_LIMIT,
	input wire logic       WRITE_OV_LIMIT,
	input wire logic [7:0] WRITE_DATA,
	input wire logic       SWITCH_ON,
	input wire logic [7:0] INPUT_UNDERVOLTAGE_LIMIT,
	input wire logic [7:0] INPUT_OVERVOLTAGE_LIMIT,
	input wire logic       OUTPUT_DISCHARGE,
	input wire logic       FAULT_OUTPUT_N,
	input wire logic [7:0] VENDOR_STATUS,
	input wire logic [2:0] SEQ_STATE
);
	logic [7:0] stby_r, stby_nxt, su_r, su_nxt;
	default clocking cb @(posedge CLOCK);
	endclocking
	default disable iff (!RESET_N);
	// Counts of standby band and start-up dwell; a count at 8'hff returns to zero on the next cycle rather than holding
	always_comb begin
		stby_nxt = (ENABLE_ABOVE_SHUTDOWN && !ENABLE_ABOVE_ON && stby_r != 8'hff) ? stby_r + 8'h01 : 8'h00;
		su_nxt   = (SEQ_STATE == ST_STARTUP && su_r != 8'hff) ? su_r + 8'h01 : 8'h00;
	end
	// Counter registers
	always_ff @(posedge CLOCK or negedge RESET_N) begin
		if (!RESET_N) begin
			stby_r <= 8'h00;
			su_r   <= 8'h00;
		end else begin
			stby_r <= stby_nxt;
			su_r   <= su_nxt;
		end
	end
	sequence s_su_late;
		(SEQ_STATE == ST_STARTUP && su_r >= SU_TIMEOUT_CYC - 3) ##1 (SEQ_STATE == ST_FAULT);
	endsequence
	property p_hold_off; SEQ_STATE inside {ST_LOCKOUT, ST_INSDLY, ST_WAIT_EN} |-> !SWITCH_ON; endproperty
	property p_switch_enable_off; !SWITCH_ENABLE [*4] |-> !SWITCH_ON; endproperty
	property p_pin_off; !ENABLE_ABOVE_ON [*4] |-> !SWITCH_ON; endproperty
	property p_ov_off; INPUT_ABOVE_OV [*4] |-> !SWITCH_ON && VENDOR_STATUS[0]; endproperty
	property p_hot_off; THERMAL_SHUTDOWN [*4] |-> !SWITCH_ON; endproperty
	property p_sd_clear;
		!ENABLE_ABOVE_SHUTDOWN [*4] |-> FAULT_OUTPUT_N && !VENDOR_STATUS[6] && SEQ_STATE == ST_LOCKOUT;
	endproperty
	property p_qod_late; stby_r == ARM_CYC + 4 |-> OUTPUT_DISCHARGE; endproperty
	property p_qod_early; $rose(OUTPUT_DISCHARGE) |-> stby_r >= ARM_CYC; endproperty
	property p_su_bound; su_r <= SU_TIMEOUT_CYC + 2; endproperty
	property p_su_fault; s_su_late |-> ##[0:1] (VENDOR_STATUS[6] && !FAULT_OUTPUT_N); endproperty
	property p_uv_wr;
		ENABLE_ABOVE_SHUTDOWN [*4] ##0 (WRITE_UV_LIMIT && !NVM_VALID) |=> INPUT_UNDERVOLTAGE_LIMIT == $past(WRITE_DATA);
	endproperty
	property p_ov_wr;
		ENABLE_ABOVE_SHUTDOWN [*4] ##0 (WRITE_OV_LIMIT && !NVM_VALID) |=> INPUT_OVERVOLTAGE_LIMIT == $past(WRITE_DATA);
	endproperty
	a_hold_off: assert property (p_hold_off) else $error("switch on before enable wait done");
	a_switch_enable_off: assert property (p_switch_enable_off) else $error("switch on with switch enable low");
	a_pin_off: assert property (p_pin_off) else $error("switch on with enable pin low");
	a_ov_off: assert property (p_ov_off) else $error("switch on during overvoltage");
	a_hot_off: assert property (p_hot_off) else $error("switch on while overheated");
	a_sd_clear: assert property (p_sd_clear) else $error("shutdown left state behind");
	a_qod_late: assert property (p_qod_late) else $error("discharge missing after standby");
	a_qod_early: assert property (p_qod_early) else $error("discharge too early");
	a_su_bound: assert property (p_su_bound) else $error("start-up outlived timeout");
	a_su_fault: assert property (p_su_fault) else $error("start-up timeout not flagged");
	a_uv_wr: assert property (p_uv_wr) else $error("undervoltage limit write lost");
	a_ov_wr: assert property (p_ov_wr) else $error("overvoltage limit write lost");
endmodule
bind efuse_seq efuse_seq_props #(.ARM_CYC(ARM_CYC), .SU_TIMEOUT_CYC(SU_TIMEOUT_CYC)) u_props (
	.CLOCK(CLOCK), .RESET_N(RESET_N), .ENABLE_ABOVE_ON(ENABLE_ABOVE_ON),
	.ENABLE_ABOVE_SHUTDOWN(ENABLE_ABOVE_SHUTDOWN), .SWITCH_ENABLE(SWITCH_ENABLE),
	.INPUT_ABOVE_OV(INPUT_ABOVE_OV), .THERMAL_SHUTDOWN(THERMAL_SHUTDOWN), .NVM_VALID(NVM_VALID),
	.WRITE_UV_LIMIT(WRITE_UV_LIMIT), .WRITE_OV_LIMIT(WRITE_OV_LIMIT), .WRITE_DATA(WRITE_DATA),
	.SWITCH_ON(SWITCH_ON), .INPUT_UNDERVOLTAGE_LIMIT(INPUT_UNDERVOLTAGE_LIMIT),
	.INPUT_OVERVOLTAGE_LIMIT(INPUT_OVERVOLTAGE_LIMIT), .OUTPUT_DISCHARGE(OUTPUT_DISCHARGE),
	.FAULT_OUTPUT_N(FAULT_OUTPUT_N), .VENDOR_STATUS(VENDOR_STATUS), .SEQ_STATE(SEQ_STATE)
);
`default_nettype wire

// >>> sim/host_ctl.sv
// Host side model: turns a commanded mode into enable pin bands and switch enable.
// Assumes the bench changes mode and request just after a clock edge.
`timescale 1ns/1ps
`default_nettype none
module host_ctl (
	input  wire logic [1:0] mode,
	input  wire logic       switch_enable_req,
	output logic            above_on,
	output logic            above_sd,
	output logic            switch_enable
);
	// Mode 0 shutdown, 1 standby band, 2 fully on; pin bands nest, so on implies above shutdown
	assign above_sd = (mode != 2'h0);
	assign above_on = (mode == 2'h2);
	assign switch_enable     = switch_enable_req;
endmodule
`default_nettype wire

// >>> sim/tb_top.sv
// Self-checking bench for the fuse sequencer.
// Assumes the bound checker and shortened timer parameters below.
`timescale 1ns/1ps
`default_nettype none
module tb_top;
	import efuse_seq_pkg::*;
	typedef struct packed { logic [1:0] kind; logic [7:0] data; logic [7:0] exp; } row_t;
	logic       clk = 1'b0, reset_n = 1'b0, bias = 1'b0, ov = 1'b0, brk = 1'b0, full = 1'b0, nvm_v = 1'b0;
	logic       switch_enable_req = 1'b1, w_uv = 1'b0, w_ov = 1'b0, w_sl = 1'b0, w_bl = 1'b0;
	logic       nvm_retry = 1'b0, below_uv = 1'b1;
	logic [1:0] nvm_slew = 2'h1;
	logic [2:0] hard = 3'h0;
	logic [7:0] nvm_dly = 8'h02, nvm_uvl = 8'h33, nvm_ovl = 8'hb0, nvm_blank = 8'h14;
	logic [1:0] mode = 2'h2;
	logic [7:0] wdata = 8'h00;
	logic       above_on, above_sd, switch_enable, sw_on, slew_c, output_discharge, fault_n;
	logic [1:0] slew;
	logic [7:0] uv, ovl, status;
	logic [2:0] sq;
	int         err_count = 0, compares = 0, n;
	row_t       rows [6];
	// 125 MHz core clock
	always #4 clk = ~clk;
	host_ctl u_host (.mode(mode), .switch_enable_req(switch_enable_req), .above_on(above_on), .above_sd(above_sd), .switch_enable(switch_enable));
	efuse_seq #(.INS_STEP_CYC(4), .ARM_CYC(20), .SU_TIMEOUT_CYC(50), .OC_STEP_CYC(4), .RETRY_STEP_CYC(8)) u_dut (
		.CLOCK(clk), .RESET_N(reset_n), .BIAS_ABOVE_UVP(bias), .ENABLE_ABOVE_ON(above_on),
		.ENABLE_ABOVE_SHUTDOWN(above_sd), .SWITCH_ENABLE(switch_enable), .INPUT_BELOW_UV(below_uv), .INPUT_ABOVE_OV(ov),
		.CURRENT_ABOVE_BREAKER(brk), .CURRENT_ABOVE_PROG_TRIP(hard[0]), .CURRENT_ABOVE_FIXED_TRIP(hard[1]),
		.THERMAL_SHUTDOWN(hard[2]), .SWITCH_FULLY_ON(full), .NVM_VALID(nvm_v), .NVM_INSERTION_DELAY(nvm_dly),
		.NVM_UV_LIMIT(nvm_uvl), .NVM_OV_LIMIT(nvm_ovl), .NVM_BLANKING(nvm_blank), .NVM_SLEW_SCALE(nvm_slew),
		.NVM_AUTO_RETRY(nvm_retry), .WRITE_UV_LIMIT(w_uv), .WRITE_OV_LIMIT(w_ov), .WRITE_SLEW_SCALE(w_sl),
		.WRITE_BLANKING(w_bl), .WRITE_DATA(wdata), .SWITCH_ON(sw_on), .SLEW_CONTROLLED(slew_c),
		.SLEW_SCALE(slew), .INPUT_UNDERVOLTAGE_LIMIT(uv), .INPUT_OVERVOLTAGE_LIMIT(ovl),
		.OUTPUT_DISCHARGE(output_discharge), .FAULT_OUTPUT_N(fault_n), .VENDOR_STATUS(status), .SEQ_STATE(sq)
	);
	task automatic final_report;
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s expected %h seen %h", nm, exp, got);
		end
	endtask
	// Bounded wait for a sequencer state; running out ends the run
	task automatic wait_st(input seq_state_t s, input int lim);
		n = 0;
		while (sq !== s && n < lim) begin
			@(posedge clk);
			#1;
			n++;
		end
		if (sq !== s) begin
			err_count++;
			$display("unexpected state expected %h seen %h", s, sq);
			final_report;
		end
	endtask
	// One-cycle write strobe; kind 0 uv, 1 ov, 2 slew, 3 blanking
	task automatic wr(input logic [1:0] k, input logic [7:0] d);
		@(posedge clk);
		{w_bl, w_sl, w_ov, w_uv} <= 4'h1 << k;
		wdata <= d;
		@(posedge clk);
		{w_bl, w_sl, w_ov, w_uv} <= 4'h0;
		#1;
	endtask
	initial begin
		rows = '{'{2'h0, 8'h5a, 8'h5a}, '{2'h1, 8'ha5, 8'ha5}, '{2'h2, 8'hfd, 8'h01},
			'{2'h2, 8'h00, 8'h00}, '{2'h2, 8'h02, 8'h02}, '{2'h2, 8'h07, 8'h03}};
		repeat (8) @(posedge clk);
		reset_n <= 1'b1;
		@(posedge clk);
		#1;
		chk("switch", 8'h00, {7'h0, sw_on});
		chk("fault_n", 8'h01, {7'h0, fault_n});
		chk("uv", 8'h20, uv);
		chk("ov", 8'hc0, ovl);
		chk("slew", 8'h02, {6'h0, slew});
		// Table of run-time configuration writes
		foreach (rows[i]) begin
			wr(rows[i].kind, rows[i].data);
			chk("cfg", rows[i].exp, (rows[i].kind == 2'h0) ? uv : (rows[i].kind == 2'h1) ? ovl : {6'h0, slew});
		end
		// Image load at power-up overrides the written values once
		@(posedge clk);
		nvm_v <= 1'b1;
		@(posedge clk);
		nvm_v <= 1'b0;
		@(posedge clk);
		#1;
		chk("nvm uv", 8'h33, uv);
		chk("nvm ov", 8'hb0, ovl);
		chk("nvm slew", 8'h01, {6'h0, slew});
		@(posedge clk);
		bias     <= 1'b1;
		below_uv <= 1'b0;
		wait_st(ST_INSDLY, 10);
		n = 0;
		while (sq === ST_INSDLY && n < 200) begin
			@(posedge clk);
			#1;
			n++;
		end
		chk("insdly", 8'd12, n[7:0]);
		wait_st(ST_STARTUP, 10);
		chk("switch", 8'h01, {7'h0, sw_on});
		@(posedge clk);
		full <= 1'b1;
		wait_st(ST_ON, 10);
		// Overvoltage cut then slew-controlled return
		@(posedge clk);
		ov <= 1'b1;
		repeat (5) @(posedge clk);
		#1;
		chk("ov switch", 8'h00, {7'h0, sw_on});
		@(posedge clk);
		ov <= 1'b0;
		wait_st(ST_STARTUP, 20);
		chk("slew ctl", 8'h01, {7'h0, slew_c});
		wait_st(ST_ON, 10);
		// Short peaks must each see the full blanking interval, a long one trips and latches
		wr(2'h3, 8'h02);
		repeat (5) begin
			brk <= 1'b1;
			repeat (2) @(posedge clk);
			brk <= 1'b0;
			repeat (4) @(posedge clk);
		end
		#1;
		chk("peaks", ST_ON, {5'h0, sq});
		@(posedge clk);
		brk <= 1'b1;
		wait_st(ST_FAULT, 40);
		chk("trip", 8'h00, {7'h0, sw_on});
		chk("trip fault_n", 8'h00, {7'h0, fault_n});
		brk <= 1'b0;
		repeat (20) @(posedge clk);
		#1;
		chk("latched", ST_FAULT, {5'h0, sq});
		// Shutdown band clears everything, standby band arms discharge
		@(posedge clk);
		mode <= 2'h0;
		repeat (6) @(posedge clk);
		#1;
		chk("sd state", 8'h00, {5'h0, sq});
		chk("sd uv", 8'h20, uv);
		@(posedge clk);
		mode <= 2'h1;
		full <= 1'b0;
		repeat (27) @(posedge clk);
		#1;
		chk("discharge", 8'h01, {7'h0, output_discharge});
		@(posedge clk);
		mode <= 2'h2;
		wait_st(ST_STARTUP, 100);
		// Fixed trip is only honoured once steady, so start-up carries on
		@(posedge clk);
		hard <= 3'h2;
		repeat (4) @(posedge clk);
		#1;
		chk("fixed trip startup", 8'h01, {7'h0, sw_on});
		wait_st(ST_FAULT, 80);
		@(posedge clk);
		#1;
		chk("timeout bit", 8'h40, status & 8'h40);
		chk("timeout fault_n", 8'h00, {7'h0, fault_n});
		// Second image after shutdown brings auto-retry; each hard fault cuts, flags and recovers
		@(posedge clk);
		mode      <= 2'h0;
		hard      <= 3'h0;
		nvm_retry <= 1'b1;
		nvm_uvl   <= 8'h44;
		repeat (4) @(posedge clk);
		mode  <= 2'h2;
		nvm_v <= 1'b1;
		full  <= 1'b1;
		wait_st(ST_ON, 60);
		chk("reload uv", 8'h44, uv);
		@(posedge clk);
		nvm_v    <= 1'b0;
		switch_enable_req <= 1'b0;
		repeat (4) @(posedge clk);
		#1;
		chk("switch_enable switch", 8'h00, {7'h0, sw_on});
		chk("switch_enable state", ST_WAIT_EN, {5'h0, sq});
		@(posedge clk);
		switch_enable_req <= 1'b1;
		wait_st(ST_ON, 10);
		// Programmable trip, fixed trip, then thermal shutdown in steady state
		for (int k = 0; k < 3; k++) begin
			@(posedge clk);
			hard <= 3'h1 << k;
			wait_st(ST_FAULT, 10);
			chk("hard switch", 8'h00, {7'h0, sw_on});
			chk("hard fault_n", 8'h00, {7'h0, fault_n});
			@(posedge clk);
			hard <= 3'h0;
			wait_st(ST_WAIT_EN, 40);
			chk("retry fault_n", 8'h01, {7'h0, fault_n});
			wait_st(ST_ON, 10);
		end
		// Input undervoltage alone drops back to lockout
		@(posedge clk);
		below_uv <= 1'b1;
		wait_st(ST_LOCKOUT, 10);
		chk("uv switch", 8'h00, {7'h0, sw_on});
		final_report;
	end
endmodule
`default_nettype wire
